// ### rcts_top.sv
// reference clock trim, oscillator ready status and protected fast rc tuning
`timescale 1ns/1ps
`include "rcts_consts.svh"
module rcts_top
	import rcts_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`RCTS_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [`RCTS_DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [`RCTS_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [`RCTS_DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic pllLocked,
	input wire logic lowPowerRcReady,
	input wire logic secondaryOscReady,
	input wire logic primaryOscReady,
	input wire logic pllPostscalerReady,
	input wire logic fastRcReady,
	output logic refEnable,
	output logic refActive,
	output logic refClkOut,
	output logic refTick,
	output logic [`RCTS_TUNE_W-1:0] tuningCode
);
	logic awHeldQ, awHeldD, wHeldQ, wHeldD, bvalidQ, bvalidD, rvalidQ, rvalidD;
	logic [`RCTS_ADDR_W-1:0] awAddrQ, awAddrD, wrAddr;
	logic [`RCTS_DATA_W-1:0] wDataQ, wDataD, wrData, rdataQ, rdataD, merged, statusWord;
	logic [3:0] wStrbQ, wStrbD, wrStrb;
	logic [1:0] brespQ, brespD, rrespQ, rrespD;
	logic haveAw, haveW, doWrite, wrCtrl, wrTrim, wrTune, wrKey, swSetByWrite;
	logic [`RCTS_DIV_W-1:0] divPendQ, divPendD, divApplQ, divApplD;
	logic [`RCTS_TRIM_W-1:0] trimPendQ, trimPendD, trimApplQ, trimApplD;
	logic [`RCTS_TUNE_W-1:0] tuneQ, tuneD;
	logic enableQ, enableD, activeQ, activeD, swReqQ, swReqD;
	logic [`RCTS_DATA_W-1:0] statusQ, statusD;
	logic [`RCTS_RDY_W-1:0] rdyRaw, rdySync;
	rcts_sw_e swStateQ, swStateD;
	rcts_lock_e lockQ, lockD;

	// byte-lane merge of a write into the current register image
	function automatic logic [`RCTS_DATA_W-1:0] mergeBytes(
		input logic [`RCTS_DATA_W-1:0] oldVal,
		input logic [`RCTS_DATA_W-1:0] newVal,
		input logic [3:0] strb
	);
		logic [`RCTS_DATA_W-1:0] res;
		res = oldVal;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = newVal[b*8 +: 8];
			end
		end
		return res;
	endfunction : mergeBytes

	assign rdyRaw = {pllLocked, lowPowerRcReady, secondaryOscReady, primaryOscReady,
		pllPostscalerReady, fastRcReady};

	rcts_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.asyncIn(rdyRaw),
		.syncOut(rdySync)
	);

	always_comb begin
		statusD = `RCTS_ZERO32;
		statusD[`RCTS_ST_PLL] = rdySync[5];
		statusD[`RCTS_ST_LOW_POWER_RC_OSCILLATOR] = rdySync[4];
		statusD[`RCTS_ST_SEC] = rdySync[3];
		statusD[`RCTS_ST_PRI] = rdySync[2];
		statusD[`RCTS_ST_POST] = rdySync[1];
		statusD[`RCTS_ST_FRC] = rdySync[0];
	end

	assign statusWord = statusQ & `RCTS_ST_USED;

	// write channel: address and data may arrive in either order
	assign awready = !awHeldQ && !bvalidQ;
	assign wready = !wHeldQ && !bvalidQ;
	assign haveAw = awHeldQ || (awvalid && awready);
	assign haveW = wHeldQ || (wvalid && wready);
	assign doWrite = haveAw && haveW;
	assign wrAddr = awHeldQ ? awAddrQ : awaddr;
	assign wrData = wHeldQ ? wDataQ : wdata;
	assign wrStrb = wHeldQ ? wStrbQ : wstrb;
	assign wrCtrl = doWrite && (wrAddr == `RCTS_OFF_CTRL);
	assign wrTrim = doWrite && (wrAddr == `RCTS_OFF_TRIM);
	assign wrTune = doWrite && (wrAddr == `RCTS_OFF_TUNE);
	assign wrKey = doWrite && (wrAddr == `RCTS_OFF_KEY);

	always_comb begin
		awHeldD = awHeldQ;
		awAddrD = awAddrQ;
		wHeldD = wHeldQ;
		wDataD = wDataQ;
		wStrbD = wStrbQ;
		bvalidD = bvalidQ;
		brespD = brespQ;
		merged = `RCTS_ZERO32;
		if (bvalidQ && bready) begin
			bvalidD = 1'b0;
		end
		if (doWrite) begin
			awHeldD = 1'b0;
			wHeldD = 1'b0;
			bvalidD = 1'b1;
			brespD = `RCTS_RESP_OKAY;
			if (wrAddr == `RCTS_OFF_CTRL) begin
				merged = {1'b0, divPendQ, enableQ, 5'h00, swReqQ, activeQ, 8'h00};
			end else if (wrAddr == `RCTS_OFF_TRIM) begin
				merged = {trimPendQ, 23'h000000};
			end else if (wrAddr == `RCTS_OFF_TUNE) begin
				merged = {26'h0000000, tuneQ};
			end else if (wrAddr == `RCTS_OFF_KEY || wrAddr == `RCTS_OFF_STAT) begin
				merged = `RCTS_ZERO32;
			end else begin
				brespD = `RCTS_RESP_SLVERR;
			end
			merged = mergeBytes(merged, wrData, wrStrb);
		end else begin
			if (awvalid && awready) begin
				awHeldD = 1'b1;
				awAddrD = awaddr;
			end
			if (wvalid && wready) begin
				wHeldD = 1'b1;
				wDataD = wdata;
				wStrbD = wstrb;
			end
		end
	end

	// reference control, trim and divider switch sequencing
	assign swSetByWrite = wrCtrl && merged[`RCTS_SWREQ_BIT];

	always_comb begin
		divPendD = divPendQ;
		trimPendD = trimPendQ;
		enableD = enableQ;
		swReqD = swReqQ;
		swStateD = swStateQ;
		activeD = enableQ;
		if (wrCtrl) begin
			divPendD = merged[`RCTS_DIV_HI:`RCTS_DIV_LO];
			enableD = merged[`RCTS_EN_BIT];
		end
		if (wrTrim) begin
			trimPendD = merged[`RCTS_TRIM_HI:`RCTS_TRIM_LO];
		end
		case (swStateQ)
			RCTS_SW_IDLE: begin
				if (swReqQ) begin
					swStateD = RCTS_SW_LOAD;
				end
			end
			RCTS_SW_LOAD: begin
				swStateD = RCTS_SW_DONE;
			end
			RCTS_SW_DONE: begin
				swReqD = 1'b0;
				swStateD = RCTS_SW_IDLE;
			end
			default: begin
				swStateD = RCTS_SW_IDLE;
			end
		endcase
		// a new request in the completing cycle must not be lost
		if (swSetByWrite) begin
			swReqD = 1'b1;
		end
	end

	always_comb begin
		divApplD = divApplQ;
		trimApplD = trimApplQ;
		if (!enableQ) begin
			divApplD = divPendD;
			trimApplD = trimPendD;
		end else if (swStateQ == RCTS_SW_LOAD) begin
			divApplD = divPendQ;
			trimApplD = trimPendQ;
		end
	end

	// write protection: two keys in a row open, any other key value closes
	always_comb begin
		lockD = lockQ;
		tuneD = tuneQ;
		if (wrKey) begin
			if (merged == `RCTS_KEY1) begin
				lockD = RCTS_LK_HALF;
			end else if (merged == `RCTS_KEY2 && lockQ == RCTS_LK_HALF) begin
				lockD = RCTS_LK_OPEN;
			end else begin
				lockD = RCTS_LK_LOCKED;
			end
		end
		if (wrTune && lockQ == RCTS_LK_OPEN) begin
			tuneD = merged[`RCTS_TUNE_HI:`RCTS_TUNE_LO];
		end
	end

	// read channel, one cycle answer
	assign arready = !rvalidQ;

	always_comb begin
		rvalidD = rvalidQ;
		rdataD = rdataQ;
		rrespD = rrespQ;
		if (rvalidQ && rready) begin
			rvalidD = 1'b0;
		end
		if (arvalid && arready) begin
			rvalidD = 1'b1;
			rrespD = `RCTS_RESP_OKAY;
			if (araddr == `RCTS_OFF_CTRL) begin
				// active shows whether the enable has been taken; software compares it
				rdataD = {1'b0, divPendQ, enableQ, 5'h00, swReqQ, activeQ, 8'h00};
			end else if (araddr == `RCTS_OFF_TRIM) begin
				rdataD = {trimPendQ, 23'h000000};
			end else if (araddr == `RCTS_OFF_STAT) begin
				rdataD = statusWord;
			end else if (araddr == `RCTS_OFF_TUNE) begin
				rdataD = {26'h0000000, tuneQ};
			end else if (araddr == `RCTS_OFF_KEY) begin
				rdataD = `RCTS_ZERO32;
				rdataD[`RCTS_KEY_OPEN_BIT] = (lockQ == RCTS_LK_OPEN);
			end else begin
				rdataD = `RCTS_ZERO32;
				rrespD = `RCTS_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeldQ <= 1'b0;
			awAddrQ <= '0;
			wHeldQ <= 1'b0;
			wDataQ <= `RCTS_ZERO32;
			wStrbQ <= 4'h0;
			bvalidQ <= 1'b0;
			brespQ <= `RCTS_RESP_OKAY;
			rvalidQ <= 1'b0;
			rdataQ <= `RCTS_ZERO32;
			rrespQ <= `RCTS_RESP_OKAY;
			divPendQ <= `RCTS_DIV_RST;
			divApplQ <= `RCTS_DIV_RST;
			trimPendQ <= `RCTS_TRIM_RST;
			trimApplQ <= `RCTS_TRIM_RST;
			enableQ <= 1'b0;
			activeQ <= 1'b0;
			swReqQ <= 1'b0;
			swStateQ <= RCTS_SW_IDLE;
			lockQ <= RCTS_LK_LOCKED;
			tuneQ <= `RCTS_TUNE_RST;
			statusQ <= `RCTS_ZERO32;
		end else begin
			awHeldQ <= awHeldD;
			awAddrQ <= awAddrD;
			wHeldQ <= wHeldD;
			wDataQ <= wDataD;
			wStrbQ <= wStrbD;
			bvalidQ <= bvalidD;
			brespQ <= brespD;
			rvalidQ <= rvalidD;
			rdataQ <= rdataD;
			rrespQ <= rrespD;
			divPendQ <= divPendD;
			divApplQ <= divApplD;
			trimPendQ <= trimPendD;
			trimApplQ <= trimApplD;
			enableQ <= enableD;
			activeQ <= activeD;
			swReqQ <= swReqD;
			swStateQ <= swStateD;
			lockQ <= lockD;
			tuneQ <= tuneD;
			statusQ <= statusD;
		end
	end

	rcts_frac_div u_div (
		.clk(clk),
		.rst_n(rst_n),
		.run(activeQ),
		.divider(divApplQ),
		.trim(trimApplQ),
		.refClkOut(refClkOut),
		.refTick(refTick)
	);

	assign bvalid = bvalidQ;
	assign bresp = brespQ;
	assign rvalid = rvalidQ;
	assign rdata = rdataQ;
	assign rresp = rrespQ;
	assign refEnable = enableQ;
	assign refActive = activeQ;
	assign tuningCode = tuneQ;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_TRIM_WAITS_SWITCH: assert property (
		(enableQ && swStateQ != RCTS_SW_LOAD) |=> $stable(trimApplQ))
		else $error("trim applied without a divider switch");
	AST_TRIM_DIRECT_WHEN_OFF: assert property (
		(!enableQ) |=> (trimApplQ == trimPendQ))
		else $error("trim not applied directly while disabled");
	AST_SWITCH_COMPLETES: assert property (
		(swReqQ && swStateQ == RCTS_SW_IDLE) |=> (swStateQ == RCTS_SW_LOAD) ##1
		(swStateQ == RCTS_SW_DONE) ##1 (!swReqQ || $past(swSetByWrite)))
		else $error("divider switch did not complete in three cycles");
	AST_SWITCH_HELD: assert property (
		(swReqQ && swStateQ != RCTS_SW_DONE) |=> swReqQ)
		else $error("switch request dropped early");
	AST_PLL_STATUS: assert property (
		pllLocked [*4] |-> statusWord[`RCTS_ST_PLL])
		else $error("pll lock not shown within sync delay");
	AST_FRC_STATUS: assert property (
		(!fastRcReady) [*4] |-> !statusWord[`RCTS_ST_FRC])
		else $error("fast rc ready shown while not ready");
	AST_TUNE_LOCKED: assert property (
		(wrTune && lockQ != RCTS_LK_OPEN) |=> $stable(tuningCode))
		else $error("tuning changed without unlock");
	AST_TUNE_UNLOCKED: assert property (
		(wrTune && lockQ == RCTS_LK_OPEN) |=> (tuningCode == $past(merged[5:0])))
		else $error("unlocked tuning write not taken");
	AST_TRIM_LOW_ZERO: assert property (
		(arvalid && arready && araddr == `RCTS_OFF_TRIM) |=> (rdata[22:0] == 23'h000000))
		else $error("trim reserved bits not zero");
	AST_WRITE_ANSWER: assert property (doWrite |=> (bvalid && !awready && !wready))
		else $error("write not answered next cycle");
endmodule : rcts_top

// ### rcts_consts.svh
// register map, field positions, reset values and keys of the reference clock trim block
`ifndef RCTS_CONSTS_SVH
`define RCTS_CONSTS_SVH

`define RCTS_ADDR_W 8
`define RCTS_DATA_W 32
`define RCTS_OFF_CTRL 8'h00
`define RCTS_OFF_TRIM 8'h04
`define RCTS_OFF_STAT 8'h08
`define RCTS_OFF_TUNE 8'h0c
`define RCTS_OFF_KEY 8'h10

`define RCTS_DIV_HI 30
`define RCTS_DIV_LO 16
`define RCTS_DIV_W 15
`define RCTS_EN_BIT 15
`define RCTS_SWREQ_BIT 9
`define RCTS_ACT_BIT 8
`define RCTS_TRIM_HI 31
`define RCTS_TRIM_LO 23
`define RCTS_TRIM_W 9
`define RCTS_TUNE_HI 5
`define RCTS_TUNE_LO 0
`define RCTS_TUNE_W 6

`define RCTS_RDY_W 6
`define RCTS_ST_PLL 7
`define RCTS_ST_LOW_POWER_RC_OSCILLATOR 5
`define RCTS_ST_SEC 4
`define RCTS_ST_PRI 2
`define RCTS_ST_POST 1
`define RCTS_ST_FRC 0
`define RCTS_ST_USED 32'h000000b7

`define RCTS_KEY_OPEN_BIT 0
`define RCTS_KEY1 32'haa996655
`define RCTS_KEY2 32'h556699aa

`define RCTS_RESP_OKAY 2'b00
`define RCTS_RESP_SLVERR 2'b10
`define RCTS_ZERO32 32'h00000000
`define RCTS_DIV_RST 15'h0000
`define RCTS_TRIM_RST 9'h000
`define RCTS_TUNE_RST 6'h00

`endif

// ### rcts_pkg.sv
// types of the reference clock trim block
package rcts_pkg;

	typedef enum logic [1:0] {
		RCTS_SW_IDLE = 2'b00,
		RCTS_SW_LOAD = 2'b01,
		RCTS_SW_DONE = 2'b11
	} rcts_sw_e;

	typedef enum logic [1:0] {
		RCTS_LK_LOCKED = 2'b00,
		RCTS_LK_HALF = 2'b01,
		RCTS_LK_OPEN = 2'b11
	} rcts_lock_e;

endpackage : rcts_pkg

// ### rcts_sync.sv
// two-flop synchronisers for the oscillator ready inputs
`timescale 1ns/1ps
`include "rcts_consts.svh"
module rcts_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`RCTS_RDY_W-1:0] asyncIn,
	output logic [`RCTS_RDY_W-1:0] syncOut
);
	logic [`RCTS_RDY_W-1:0] metaQ;

	genvar i;
	generate
		for (i = 0; i < `RCTS_RDY_W; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					metaQ[i] <= 1'b0;
					syncOut[i] <= 1'b0;
				end else begin
					metaQ[i] <= asyncIn[i];
					syncOut[i] <= metaQ[i];
				end
			end
		end
	endgenerate
endmodule : rcts_sync

// ### rcts_frac_div.sv
// fractional reference divider: half period of divider plus trim/512 cycles, one cycle when divider is zero
`timescale 1ns/1ps
`include "rcts_consts.svh"
module rcts_frac_div (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [`RCTS_DIV_W-1:0] divider,
	input wire logic [`RCTS_TRIM_W-1:0] trim,
	output logic refClkOut,
	output logic refTick
);
	logic [`RCTS_DIV_W-1:0] cntQ, cntD, lastCnt;
	logic [`RCTS_TRIM_W-1:0] accQ, accD;
	logic extraQ, extraD, outQ, outD, tickQ, tickD;
	logic [`RCTS_TRIM_W:0] sum;

	always_comb begin
		cntD = cntQ;
		accD = accQ;
		extraD = extraQ;
		outD = outQ;
		tickD = 1'b0;
		// a carry out of the accumulator stretches the next half period by one cycle
		lastCnt = divider - `RCTS_DIV_W'(1) + `RCTS_DIV_W'(extraQ);
		sum = {1'b0, accQ} + {1'b0, trim};
		if (!run) begin
			cntD = `RCTS_DIV_RST;
			accD = `RCTS_TRIM_RST;
			extraD = 1'b0;
			outD = 1'b0;
		end else if (divider == `RCTS_DIV_RST) begin
			// no division: every source edge is an output edge, trim unused
			cntD = `RCTS_DIV_RST;
			accD = `RCTS_TRIM_RST;
			extraD = 1'b0;
			outD = !outQ;
			tickD = 1'b1;
		end else if (cntQ >= lastCnt) begin
			cntD = `RCTS_DIV_RST;
			accD = sum[`RCTS_TRIM_W-1:0];
			extraD = sum[`RCTS_TRIM_W];
			outD = !outQ;
			tickD = 1'b1;
		end else begin
			cntD = cntQ + `RCTS_DIV_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cntQ <= `RCTS_DIV_RST;
			accQ <= `RCTS_TRIM_RST;
			extraQ <= 1'b0;
			outQ <= 1'b0;
			tickQ <= 1'b0;
		end else begin
			cntQ <= cntD;
			accQ <= accD;
			extraQ <= extraD;
			outQ <= outD;
			tickQ <= tickD;
		end
	end

	assign refClkOut = outQ;
	assign refTick = tickQ;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_BYPASS_EVERY_EDGE: assert property ((run && divider == `RCTS_DIV_RST) |=> refTick)
		else $error("bypass did not tick every cycle");
	AST_NO_FRACTION_AT_ZERO: assert property ((divider == `RCTS_DIV_RST) |=> !extraQ)
		else $error("fraction applied with zero divider");
endmodule : rcts_frac_div

// ### rcts_osc_model.sv
// behavioural oscillator and pll ready model feeding the status inputs
`timescale 1ns/1ps
module rcts_osc_model #(
	parameter int SETTLE = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [5:0] want,
	output logic pllLocked,
	output logic lowPowerRcReady,
	output logic secondaryOscReady,
	output logic primaryOscReady,
	output logic pllPostscalerReady,
	output logic fastRcReady
);
	logic [5:0] rdy;
	int cnt [6];

	// ready only after a settle time, lost at once: a real clock drops without warning
	always @(posedge clk or negedge rst_n) begin
		for (int i = 0; i < 6; i++) begin
			if (!rst_n || !want[i]) begin
				cnt[i] <= 0;
				rdy[i] <= 1'b0;
			end else if (cnt[i] < SETTLE) begin
				cnt[i] <= cnt[i] + 1;
			end else begin
				rdy[i] <= 1'b1;
			end
		end
	end

	assign {pllLocked, lowPowerRcReady, secondaryOscReady} = rdy[5:3];
	assign {primaryOscReady, pllPostscalerReady, fastRcReady} = rdy[2:0];
endmodule : rcts_osc_model

// ### rcts_top_tb_top.sv
// self-checking bench for the reference clock trim and oscillator status block
`timescale 1ns/1ps
`include "rcts_consts.svh"
module rcts_top_tb_top;
	localparam int SETTLE = 4;
	logic clk, rst_n;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic pllLocked, lowPowerRcReady, secondaryOscReady;
	logic primaryOscReady, pllPostscalerReady, fastRcReady;
	logic refEnable, refActive, refClkOut, refTick;
	logic [5:0] tuningCode, want;
	int n_mismatch, compares;

	rcts_top dut_u (.clk, .rst_n, .awaddr, .awprot(3'b000), .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'b000),
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pllLocked, .lowPowerRcReady,
		.secondaryOscReady, .primaryOscReady, .pllPostscalerReady, .fastRcReady,
		.refEnable, .refActive, .refClkOut, .refTick, .tuningCode);

	rcts_osc_model #(.SETTLE(SETTLE)) osc_u (.clk, .rst_n, .want, .pllLocked,
		.lowPowerRcReady, .secondaryOscReady, .primaryOscReady, .pllPostscalerReady,
		.fastRcReady);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic give_verdict();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict

	task automatic hang();
		n_mismatch++;
		$display("[FAIL] %0t bus wait ran out", $time);
		give_verdict();
	endtask : hang

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic near(input int got, input int exp, input string m);
		compares++;
		if (got < exp - 2 || got > exp + 2) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %0d exp %0d", $time, m, got, exp);
		end
	endtask : near

	// entered just after a rising edge; leaves one edge after the answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end while (!done && n < 50);
		if (!done) hang();
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end while (!done && n < 50);
		if (!done) hang();
		@(posedge clk);
	endtask : rd

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk({30'h0, r}, 32'h0, "write response");
	endtask : w

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e, m);
	endtask : rchk

	task automatic ticks(input int c, output int t);
		t = 0;
		repeat (c) begin
			@(posedge clk);
			if (refTick === 1'b1) t++;
		end
	endtask : ticks

	task automatic test_reset();
		for (int i = 0; i < 5; i++) begin
			rchk(8'(4 * i), 32'h0, "reset value");
		end
		chk({26'h0, tuningCode}, 32'h0, "tuning after reset");
	endtask : test_reset

	task automatic test_status();
		int pos [6] = '{0, 1, 2, 4, 5, 7};
		for (int i = 0; i < 6; i++) begin
			want <= 6'(1 << i);
			repeat (SETTLE + 6) @(posedge clk);
			rchk(`RCTS_OFF_STAT, 32'(1) << pos[i], "status bit");
		end
		want <= 6'h3f;
		repeat (SETTLE + 6) @(posedge clk);
		w(`RCTS_OFF_STAT, 32'hffffffff);
		rchk(`RCTS_OFF_STAT, 32'h000000b7, "all ready");
		want <= 6'h00;
		repeat (6) @(posedge clk);
		rchk(`RCTS_OFF_STAT, 32'h0, "all lost");
	endtask : test_status

	task automatic test_tune();
		w(`RCTS_OFF_TUNE, 32'h1f);
		rchk(`RCTS_OFF_TUNE, 32'h0, "locked tune write");
		w(`RCTS_OFF_KEY, `RCTS_KEY1);
		w(`RCTS_OFF_KEY, `RCTS_KEY2);
		w(`RCTS_OFF_TUNE, 32'hffffffe0);
		rchk(`RCTS_OFF_TUNE, 32'h20, "most negative");
		chk({26'h0, tuningCode}, 32'h20, "tuning out");
		w(`RCTS_OFF_TUNE, 32'h1f);
		chk({26'h0, tuningCode}, 32'h1f, "tuning out");
		w(`RCTS_OFF_KEY, 32'h0);
		w(`RCTS_OFF_TUNE, 32'h0);
		chk({26'h0, tuningCode}, 32'h1f, "relocked tune write");
	endtask : test_tune

	task automatic test_unmapped();
		logic [31:0] d;
		logic [1:0] r;
		wr(8'h40, 32'hffffffff, r);
		chk({30'h0, r}, 32'h2, "unmapped write");
		rd(8'h40, d, r);
		chk({d[29:0], r}, 32'h2, "unmapped read");
	endtask : test_unmapped

	// software only writes trim once active has caught up with enable
	task automatic test_divider();
		int t;
		logic c0;
		w(`RCTS_OFF_TRIM, 32'hffffffff);
		rchk(`RCTS_OFF_TRIM, 32'hff800000, "trim field");
		w(`RCTS_OFF_CTRL, 32'h00020000);
		w(`RCTS_OFF_TRIM, 32'h80000000);
		w(`RCTS_OFF_CTRL, 32'h00028000);
		repeat (10) @(posedge clk);
		chk({30'h0, refEnable, refActive}, 32'h3, "enabled and active");
		ticks(200, t);
		near(t, 80, "half trim rate");
		w(`RCTS_OFF_TRIM, 32'h0);
		ticks(200, t);
		near(t, 80, "trim held back");
		w(`RCTS_OFF_CTRL, 32'h00028200);
		repeat (10) @(posedge clk);
		rchk(`RCTS_OFF_CTRL, 32'h00028100, "switch done");
		ticks(200, t);
		near(t, 100, "zero trim rate");
		w(`RCTS_OFF_TRIM, 32'h80000000);
		w(`RCTS_OFF_CTRL, 32'h00008200);
		repeat (10) @(posedge clk);
		ticks(20, t);
		chk(32'(t), 32'd20, "bypass ignores trim");
		@(posedge clk);
		c0 = refClkOut;
		@(posedge clk);
		chk({31'h0, refClkOut}, {31'h0, !c0}, "bypass clock toggles");
	endtask : test_divider

	initial begin
		rst_n = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h00000000;
		wstrb = 4'hf;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		want = 6'h00;
		n_mismatch = 0;
		compares = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		test_reset();
		test_status();
		test_tune();
		test_unmapped();
		test_divider();
		give_verdict();
	end
endmodule : rcts_top_tb_top
